// ===== xlate_pkg.sv
// Package for the virtual address translation unit: register map, field
// positions, reset values, trap codes and the carrier structs.
// Assumes a single core clock and a classic Wishbone register port.
`default_nettype none
package xlate_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_SPACE_ID = 8'h04;
  localparam logic [7:0] OFS_FAULT_ADDR = 8'h18;
  localparam logic [7:0] OFS_MAP_VADDR = 8'h20;
  localparam logic [7:0] OFS_MAP_ATTR = 8'h24;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h28;
  localparam logic [7:0] OFS_TRAP_BASE = 8'h2c;
  localparam logic [7:0] OFS_SEG_CACHE = 8'h30;
  localparam logic [7:0] OFS_TRAP_INFO = 8'h34;
  // Configuration fields
  localparam int CFG_VIRT_BIT = 0;
  localparam int CFG_SZ1_LSB = 1;
  localparam int CFG_SZ2_LSB = 3;
  localparam int CFG_LIMIT_LSB = 5;
  // Install attribute byte positions
  localparam int ATR_VALID = 31;
  localparam int ATR_FETCH = 30;
  localparam int ATR_WRITE = 29;
  localparam int ATR_LOAD = 28;
  localparam int ATR_GLOBAL = 27;
  localparam int ATR_CACHE = 26;
  localparam int ATR_SZ_LSB = 24;
  localparam int PAGE_NUM_FIELD_W = 24;
  // Status word fields
  localparam int SW_PSET_LSB = 12;
  localparam int SW_PRIV_LSB = 10;
  localparam logic [1:0] PRIV_USER0 = 2'h0;
  localparam logic [1:0] PRIV_SUPER = 2'h2;
  // Trap identities
  localparam logic [2:0] TRAP_CLASS_MMU = 3'h0;
  localparam logic [2:0] IDENT_MISS = 3'h0;
  localparam logic [2:0] IDENT_PROT = 3'h1;
  localparam int CLASS_SHIFT = 5;
  localparam int BASE_SHIFT = 10;
  // Reset values
  localparam logic [31:0] RST_CONFIG = 32'h0000_0000;
  localparam logic [31:0] RST_SEG_CACHE = 32'h0000_ffff;
  localparam logic [31:0] RST_TRAP_BASE = 32'h0000_0000;

  typedef enum logic [1:0] {
    ACC_LOAD = 2'h0,
    ACC_STORE = 2'h1,
    ACC_FETCH = 2'h2
  } acc_kind_t;

  typedef struct packed {
    logic valid;
    logic [31:0] vaddr;
    acc_kind_t kind;
    logic ctx_ptr;
  } xlate_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] paddr;
    logic cacheable;
    logic direct;
    logic [1:0] prot_set;
    logic trap;
    logic [2:0] trap_ident_num;
    logic [31:0] trap_pc;
  } xlate_rsp_t;

  typedef struct packed {
    logic valid;
    logic [4:0] space_id;
    logic [21:0] virtual_page_num;
    logic [21:0] physical_page_num;
    logic fetch_permit;
    logic write_permit;
    logic load_permit;
    logic cacheable;
    logic all_spaces;
  } lookaside_table_entry_t;
endpackage
`default_nettype wire

// ===== xlate_unit.sv
// Virtual address translation unit: direct mapping, two lookaside buffers,
// permission checks, traps and the install-mapping operation.
// Assumes the core pipeline holds a request one cycle and takes the answer
// one cycle later; registers are reached over classic Wishbone.
`default_nettype none
// Behaviour
// - Sixteen 256 MB segments by top bits
// - Upper half passes through unchanged always
// - Lower half: physical passes, virtual translates
// - Swap page number, keep page offset
// - Context pointer addresses always go direct
// - Two buffers, each one selectable page size
// - Entry limit 4..128, indexes 0/128 based
// - Entry holds space id, pages, permission bits
// - Hit needs valid, page match, global/space
// - Translated cacheability from entry bit
// - Direct cacheability from per-segment attribute
// - Direct accesses report protection set select
// - User-0 refused upper half if virtual, segments 14-15 if physical
// - Fetch, write, read gated by permits
// - Miss ident 0, protection ident 1, class 0
// - Fault address shifted by 10+2*min size
// - Ident to trap register, vector base OR class
// - Install only at supervisor privilege level
// - Install vaddr from even register, space id
// - Install page number low 24 bits, padded
// - Config bit 0 mode, two size fields
// - Attribute byte bit layout
// - Unmatched size ignored; same size one buffer
module xlate_unit
  import xlate_pkg::*;
#(
  parameter int ENTRIES = 128
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Core request and answer
  input wire xlate_req_t req_i,
  output xlate_rsp_t rsp_o,
  output logic [31:0] trap_number_gpr_o,
  output logic save_upper_ctx_o
);
  localparam int IW = $clog2(ENTRIES);
  localparam logic [6:0] LIMIT = 7'(ENTRIES - 1);

  // Limit field is 7 bits wide and every index must fit one buffer
  if (ENTRIES < 4 || ENTRIES > 128)
  begin : g_bad_entries
    $error("ENTRIES must be 4 to 128");
  end

  lookaside_table_entry_t tbl1 [ENTRIES];
  lookaside_table_entry_t tbl2 [ENTRIES];
  logic [31:0] config_ff;
  logic [4:0] space_id_ff;
  logic [31:0] fault_addr_reg_ff;
  logic [31:0] map_vaddr_ff;
  logic [31:0] status_word_ff;
  logic [31:0] trap_vector_base_ff;
  logic [15:0] seg_cache_ff;
  logic [IW-1:0] repl1_ff;
  logic [IW-1:0] repl2_ff;
  logic [2:0] last_ident_ff;
  logic last_trap_ff;
  logic [31:0] dat_ff;
  logic ack_ff;
  xlate_rsp_t rsp_ff;
  logic [31:0] gpr_ff;
  logic save_ff;

  wire logic [1:0] sz1 = config_ff[CFG_SZ1_LSB +: 2];
  wire logic [1:0] sz2 = config_ff[CFG_SZ2_LSB +: 2];
  wire logic virt_mode = config_ff[CFG_VIRT_BIT];
  wire logic [1:0] priv = status_word_ff[SW_PRIV_LSB +: 2];
  wire logic [1:0] min_sz = (sz1 < sz2) ? sz1 : sz2;

  // Page number of an address for a given size code (10 + 2*code bits)
  function automatic logic [21:0] page_of(input logic [31:0] a, input logic [1:0] sz);
    logic [31:0] s;
    s = a >> (BASE_SHIFT + 2 * int'(sz));
    return s[21:0];
  endfunction

  // Lookup, combinational, both buffers in parallel
  logic hit1;
  logic hit2;
  logic [IW-1:0] hidx1;
  logic [IW-1:0] hidx2;
  logic [21:0] page_num1;
  logic [21:0] page_num2;
  always_comb
  begin
    page_num1 = page_of(req_i.vaddr, sz1);
    page_num2 = page_of(req_i.vaddr, sz2);
    hit1 = 1'b0;
    hit2 = 1'b0;
    hidx1 = '0;
    hidx2 = '0;
    // Each buffer compares only the bits above its own page size
    for (int i = 0; i < ENTRIES; i++)
    begin
      if (tbl1[i].valid && tbl1[i].virtual_page_num == page_num1 &&
          (tbl1[i].all_spaces || tbl1[i].space_id == space_id_ff))
      begin
        hit1 = 1'b1;
        hidx1 = IW'(i);
      end
      if (tbl2[i].valid && tbl2[i].virtual_page_num == page_num2 &&
          (tbl2[i].all_spaces || tbl2[i].space_id == space_id_ff))
      begin
        hit2 = 1'b1;
        hidx2 = IW'(i);
      end
    end
  end

  // Translation decision
  lookaside_table_entry_t hit_e;
  logic [31:0] xl_addr;
  logic use_direct;
  logic miss;
  logic deny;
  logic [1:0] hsz;
  logic [31:0] offset_mask;
  always_comb
  begin
    // First buffer wins a double hit; software should not map a page twice
    if (hit1)
    begin
      hit_e = tbl1[hidx1];
      hsz = sz1;
    end
    else
    begin
      hit_e = tbl2[hidx2];
      hsz = sz2;
    end
    // Direct for upper half, physical mode, or context pointers
    use_direct = req_i.vaddr[31] || !virt_mode || req_i.ctx_ptr;
    offset_mask = (32'h1 << (BASE_SHIFT + 2 * int'(hsz))) - 32'h1;
    xl_addr = (32'(hit_e.physical_page_num) << (BASE_SHIFT + 2 * int'(hsz))) |
      (req_i.vaddr & offset_mask);
    miss = !use_direct && !(hit1 || hit2);
    deny = 1'b0;
    if (priv == PRIV_USER0)
    begin
      if (virt_mode)
        deny = req_i.vaddr[31];
      else
        deny = req_i.vaddr[31:28] == 4'he || req_i.vaddr[31:28] == 4'hf;
    end
    if (!use_direct && !miss)
    begin
      case (req_i.kind)
        ACC_FETCH: deny = deny || !hit_e.fetch_permit;
        ACC_STORE: deny = deny || !hit_e.write_permit;
        default: deny = deny || !hit_e.load_permit;
      endcase
    end
  end

  wire logic trap_now = req_i.valid && (miss || deny);
  wire logic [2:0] ident_now = miss ? IDENT_MISS : IDENT_PROT;

  // Answer to the core
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rsp_ff <= '0;
    else
    begin
      rsp_ff.valid <= req_i.valid;
      rsp_ff.paddr <= use_direct ? req_i.vaddr : xl_addr;
      rsp_ff.cacheable <= use_direct ? seg_cache_ff[req_i.vaddr[31:28]]
                                     : hit_e.cacheable;
      rsp_ff.direct <= use_direct;
      rsp_ff.prot_set <= status_word_ff[SW_PSET_LSB +: 2];
      rsp_ff.trap <= trap_now;
      rsp_ff.trap_ident_num <= ident_now;
      rsp_ff.trap_pc <= trap_vector_base_ff |
        (32'(TRAP_CLASS_MMU) << CLASS_SHIFT);
    end
  end

  // Trap side effects: save upper context, then ident into trap register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      save_ff <= 1'b0;
      gpr_ff <= '0;
    end
    else
    begin
      save_ff <= trap_now;
      if (save_ff)
        gpr_ff <= 32'(rsp_ff.trap_ident_num);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fault_addr_reg_ff <= '0;
      last_ident_ff <= '0;
      last_trap_ff <= 1'b0;
    end
    else if (trap_now)
    begin
      // Holds the last faulting address until the next trap overwrites it
      fault_addr_reg_ff <= req_i.vaddr >> (BASE_SHIFT + 2 * int'(min_sz));
      last_ident_ff <= ident_now;
      last_trap_ff <= 1'b1;
    end
  end

  // Register bus
  // The ack cycle blocks a second take of the same held request
  wire logic wb_req = cyc_i && stb_i && !ack_ff;
  wire logic wb_wr = wb_req && we_i && (sel_i == 4'hf);
  wire logic do_map = wb_wr && adr_i == OFS_MAP_ATTR && priv == PRIV_SUPER;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      config_ff <= RST_CONFIG;
      space_id_ff <= '0;
      map_vaddr_ff <= '0;
      status_word_ff <= '0;
      trap_vector_base_ff <= RST_TRAP_BASE;
      seg_cache_ff <= RST_SEG_CACHE[15:0];
    end
    else if (wb_wr)
    begin
      // Limit field is read-only: a write keeps the built size
      if (adr_i == OFS_CONFIG)
        config_ff <= {20'h0, LIMIT, dat_i[4:0]};
      else if (adr_i == OFS_SPACE_ID)
        space_id_ff <= dat_i[4:0];
      else if (adr_i == OFS_MAP_VADDR)
        map_vaddr_ff <= dat_i;
      else if (adr_i == OFS_STATUS_WORD)
        status_word_ff <= dat_i;
      else if (adr_i == OFS_TRAP_BASE)
        trap_vector_base_ff <= dat_i;
      else if (adr_i == OFS_SEG_CACHE)
        seg_cache_ff <= dat_i[15:0];
    end
  end

  // Install-mapping: odd word write triggers, even word already held
  wire logic [1:0] map_sz = dat_i[ATR_SZ_LSB +: 2];
  wire logic to1 = map_sz == sz1;
  wire logic to2 = !to1 && map_sz == sz2;
  lookaside_table_entry_t new_e;
  always_comb
  begin
    new_e.valid = dat_i[ATR_VALID];
    new_e.fetch_permit = dat_i[ATR_FETCH];
    new_e.write_permit = dat_i[ATR_WRITE];
    new_e.load_permit = dat_i[ATR_LOAD];
    new_e.all_spaces = dat_i[ATR_GLOBAL];
    new_e.cacheable = dat_i[ATR_CACHE];
    new_e.space_id = space_id_ff;
    new_e.virtual_page_num = page_of(map_vaddr_ff, map_sz);
    // Page number field is in 1 KB units: drop the extra low zero bits
    new_e.physical_page_num = 22'(dat_i[PAGE_NUM_FIELD_W-1:0] >> (2 * int'(map_sz)));
  end

  // Table storage; cleared whole on reset so no stale field leaks out
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < ENTRIES; i++)
      begin
        tbl1[i] <= '0;
        tbl2[i] <= '0;
      end
    end
    else if (do_map)
    begin
      if (to1)
        tbl1[repl1_ff] <= new_e;
      else if (to2)
        tbl2[repl2_ff] <= new_e;
    end
  end

  // Round-robin replacement pointers, one per buffer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      repl1_ff <= '0;
      repl2_ff <= '0;
    end
    else if (do_map)
    begin
      if (to1)
        repl1_ff <= (repl1_ff == IW'(ENTRIES - 1)) ? '0 : repl1_ff + IW'(1);
      else if (to2)
        repl2_ff <= (repl2_ff == IW'(ENTRIES - 1)) ? '0 : repl2_ff + IW'(1);
    end
  end

  // Read data mux; zero unless a read is taken this cycle
  logic [31:0] nxt_dat;
  always_comb
  begin
    nxt_dat = '0;
    if (wb_req && !we_i)
    begin
      // Limit field shows the built size, from reset on
      if (adr_i == OFS_CONFIG)
        nxt_dat = {20'h0, LIMIT, config_ff[4:0]};
      else if (adr_i == OFS_SPACE_ID)
        nxt_dat = {27'h0, space_id_ff};
      else if (adr_i == OFS_FAULT_ADDR)
        nxt_dat = {8'h0, fault_addr_reg_ff[23:0]};
      else if (adr_i == OFS_MAP_VADDR)
        nxt_dat = map_vaddr_ff;
      else if (adr_i == OFS_STATUS_WORD)
        nxt_dat = status_word_ff;
      else if (adr_i == OFS_TRAP_BASE)
        nxt_dat = trap_vector_base_ff;
      else if (adr_i == OFS_SEG_CACHE)
        nxt_dat = {16'h0, seg_cache_ff};
      else if (adr_i == OFS_TRAP_INFO)
        nxt_dat = {28'h0, last_trap_ff, last_ident_ff};
    end
  end

  // Ack and read data stand for exactly one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_ff <= '0;
    end
    else
    begin
      ack_ff <= wb_req;
      dat_ff <= nxt_dat;
    end
  end

  assign dat_o = dat_ff;
  assign ack_o = ack_ff;
  assign rsp_o = rsp_ff;
  assign trap_number_gpr_o = gpr_ff;
  assign save_upper_ctx_o = save_ff;
endmodule
`default_nettype wire

// ===== xlate_unit_props.sv
// Port checker for the translation unit, bound to every instance.
// Assumes one clock domain with synchronous active-high reset.
`default_nettype none
module xlate_unit_props
  import xlate_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire xlate_req_t req_i,
  input wire xlate_rsp_t rsp_o,
  input wire logic [31:0] trap_number_gpr_o,
  input wire logic save_upper_ctx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("ack held");
  property p_valid;
    rsp_o.valid == $past(req_i.valid);
  endproperty
  a_valid: assert property (p_valid) else $error("answer timing");
  property p_upper;
    req_i.valid && req_i.vaddr[31] |=> rsp_o.paddr == $past(req_i.vaddr) && rsp_o.direct;
  endproperty
  a_upper: assert property (p_upper) else $error("upper half altered");
  property p_ctx;
    req_i.valid && req_i.ctx_ptr |=> rsp_o.paddr == $past(req_i.vaddr) && rsp_o.direct;
  endproperty
  a_ctx: assert property (p_ctx) else $error("pointer translated");
  property p_miss;
    req_i.valid && (req_i.vaddr[31] || req_i.ctx_ptr)
      |=> !(rsp_o.trap && rsp_o.trap_ident_num == IDENT_MISS);
  endproperty
  a_miss: assert property (p_miss) else $error("miss on direct");
  property p_save;
    save_upper_ctx_o == (rsp_o.valid && rsp_o.trap);
  endproperty
  a_save: assert property (p_save) else $error("save pulse");
  property p_gpr;
    save_upper_ctx_o |=> trap_number_gpr_o == {29'h0, $past(rsp_o.trap_ident_num)};
  endproperty
  a_gpr: assert property (p_gpr) else $error("trap number");
  c_prot: cover property (rsp_o.trap && rsp_o.trap_ident_num == IDENT_PROT);
  c_miss: cover property (rsp_o.trap && rsp_o.trap_ident_num == IDENT_MISS);
  c_hit: cover property (rsp_o.valid && !rsp_o.direct && !rsp_o.trap);
endmodule
bind xlate_unit xlate_unit_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .req_i(req_i), .rsp_o(rsp_o),
  .trap_number_gpr_o(trap_number_gpr_o), .save_upper_ctx_o(save_upper_ctx_o));
`default_nettype wire

// ===== xlate_core_model.sv
// Core pipeline model issuing one translation request at a time.
// Assumes the answer lands one cycle after the taking edge.
`default_nettype none
module xlate_core_model
  import xlate_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Request out, answer in
  output var xlate_req_t req_o,
  input wire xlate_rsp_t rsp_i,
  input wire logic [31:0] gpr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_o = '0;
  // Idle address is inverted so a stale value can never pass for a match
  task automatic send(input logic [31:0] va, input acc_kind_t k, input logic cp,
                      output xlate_rsp_t r, output logic [31:0] g);
    @(posedge clk_i);
    req_o <= '{1'h1, va, k, cp};
    @(posedge clk_i);
    req_o <= '{1'h0, ~va, ACC_LOAD, 1'h0};
    @(posedge clk_i);
    r = rsp_i;
    @(posedge clk_i);
    g = gpr_i;
  endtask
endmodule
`default_nettype wire

// ===== xlate_unit_tb.sv
// Self-checking bench for the translation unit.
// Assumes the core model and the bound checker.
`default_nettype none
module xlate_unit_tb
  import xlate_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc_i = 1'h0;
  logic stb_i = 1'h0;
  logic we_i = 1'h0;
  logic [7:0] adr_i = '0;
  logic [3:0] sel_i = '0;
  logic [31:0] dat_i = '0;
  logic [31:0] dat_o, gpr_w, gpr, q, va;
  logic [23:0] p;
  logic ack_o;
  xlate_req_t req;
  xlate_rsp_t rsp, r;
  int n_fail = 0;
  int n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  xlate_unit #(.ENTRIES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .req_i(req), .rsp_o(rsp),
    .trap_number_gpr_o(gpr_w), .save_upper_ctx_o());
  xlate_core_model u_core (.clk_i(clk_i), .req_o(req), .rsp_i(rsp), .gpr_i(gpr_w));
  function automatic logic [31:0] pa(logic [31:0] v, logic [23:0] n, int s);
    logic [31:0] m;
    m = (32'h1 << (10 + 2 * s)) - 32'h1;
    return (({8'h0, n} << 10) & ~m) | (v & m);
  endfunction
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] s, input logic [7:0] a,
                    input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    sel_i <= s;
    adr_i <= a;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (ack_o !== 1'h1 && i < 20);
    if (ack_o !== 1'h1)
    begin
      n_fail++;
      conclude();
    end
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask
  initial
  begin
    void'($urandom(66694));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 4'hf, OFS_CONFIG, '0);
    ck(q, 32'h60);
    wb(1'h0, 4'hf, 8'h3c, '0);
    ck(q, '0);
    wb(1'h1, 4'h3, OFS_CONFIG, 32'h1f);
    wb(1'h0, 4'hf, OFS_CONFIG, '0);
    ck(q, 32'h60);
    wb(1'h1, 4'hf, OFS_TRAP_BASE, 32'h8000_0400);
    wb(1'h1, 4'hf, OFS_SEG_CACHE, 32'hfffd);
    for (int g = 0; g < 16; g++)
    begin
      u_core.send({4'(g), 28'h5a5}, ACC_LOAD, 1'h0, r, gpr);
      ck(r.paddr, {4'(g), 28'h5a5});
      ck({r.trap, r.cacheable}, {1'(g > 13), 1'(g != 1)});
    end
    ck(gpr, 32'h1);
    ck(r.trap_pc, 32'h8000_0400);
    wb(1'h1, 4'hf, OFS_STATUS_WORD, 32'h3800);
    u_core.send(32'h0100_0000, ACC_LOAD, 1'h0, r, gpr);
    ck({r.trap, r.prot_set}, 32'h3);
    for (int s = 0; s < 4; s++)
    begin
      va = {1'h0, 3'(s), 28'($urandom)};
      p = 24'($urandom) & 24'h3f_ffff;
      wb(1'h1, 4'hf, OFS_CONFIG, 32'(1 + 10 * s));
      wb(1'h1, 4'hf, OFS_SPACE_ID, 32'(s));
      u_core.send(va, ACC_LOAD, 1'h0, r, gpr);
      ck({r.trap, r.trap_ident_num}, {1'h1, IDENT_MISS});
      wb(1'h0, 4'hf, OFS_FAULT_ADDR, '0);
      ck(q, va >> (10 + 2 * s));
      wb(1'h1, 4'hf, OFS_MAP_VADDR, va);
      wb(1'h1, 4'hf, OFS_MAP_ATTR, {8'h94 | 8'(s), p});
      u_core.send(va, ACC_LOAD, 1'h0, r, gpr);
      ck(r.paddr, pa(va, p, s));
      ck({r.trap, r.cacheable}, 32'h1);
      u_core.send(va, ACC_STORE, 1'h0, r, gpr);
      ck({r.trap, r.trap_ident_num}, {1'h1, IDENT_PROT});
      wb(1'h1, 4'hf, OFS_SPACE_ID, 32'(s + 8));
      u_core.send(va, ACC_FETCH, 1'h0, r, gpr);
      ck({r.trap, r.trap_ident_num}, {1'h1, IDENT_MISS});
    end
    va = 32'h5000_3abc;
    wb(1'h1, 4'hf, OFS_CONFIG, 32'h9);
    wb(1'h1, 4'hf, OFS_MAP_VADDR, va);
    wb(1'h1, 4'hf, OFS_MAP_ATTR, {8'h9b, p});
    u_core.send(va, ACC_LOAD, 1'h0, r, gpr);
    ck({r.trap, r.trap_ident_num}, {1'h1, IDENT_MISS});
    wb(1'h1, 4'hf, OFS_MAP_ATTR, {8'h9d, p});
    u_core.send(va, ACC_LOAD, 1'h0, r, gpr);
    ck(32'(r.trap), 32'h0);
    ck(r.paddr, pa(va, p, 1));
    wb(1'h1, 4'hf, OFS_STATUS_WORD, '0);
    u_core.send(32'hc000_0010, ACC_LOAD, 1'h0, r, gpr);
    ck({r.trap, r.trap_ident_num}, {1'h1, IDENT_PROT});
    u_core.send(32'h2000_0040, ACC_LOAD, 1'h1, r, gpr);
    ck(32'(r.trap), 32'h0);
    ck(r.paddr, 32'h2000_0040);
    wb(1'h1, 4'hf, OFS_MAP_VADDR, 32'h6000_0000);
    wb(1'h1, 4'hf, OFS_MAP_ATTR, {8'h9d, p});
    u_core.send(32'h6000_0000, ACC_LOAD, 1'h0, r, gpr);
    ck({r.trap, r.trap_ident_num}, {1'h1, IDENT_MISS});
    conclude();
  end
endmodule
`default_nettype wire
